// ==== pkg/ucc_cfg.svh ====
// Functional notes
// - Counting clock is the system clock or the low-power clock, by select field.
// - Free run works only when counting up; never enable it with down counting.
// - Timer interrupt reaches the processor only while its enable field is set.
// - Counter counts up or down according to the direction field.
// - Software-written reload value is the threshold or restart value.
// - Counting needs both the clock gate field and the timer enable field.
// - Capture mode snapshots timer count or RTC count on a selected pin edge.
// - Falling edge select 0 picks rising edges, 1 picks falling edges.
// - Count mode select 0 is capture mode, 1 is counting mode.
// - A channel event raises an interrupt only when its enable field is 1.
// - Snapshot source select chooses RTC count or timer count for capture.
// - Trigger pin select values 1 to 12 pick port pins 0 to 11.
// - The result register holds the value before the channel interrupt shows.
// - Writing 1 to a channel event clear clears its pending event.
// - Period limit holds number of input periods counted, plus one.
// - Counting mode result is timer clock cycles over the programmed periods.
// - Counter is 11 bits; reaching zero, also by wrap, raises the interrupt.
// - Snapshot is 11 bits from the timer, 22 bits from the RTC port.
// - New edge while pending discards snapshot, sets overrun; clears with event.
// - Counting mode starts the next group of events automatically.
`ifndef UCC_CFG_SVH
`define UCC_CFG_SVH
// Register offsets (byte addresses)
`define UCC_OFS_CTRL   8'h00
`define UCC_OFS_CAP1   8'h04
`define UCC_OFS_CAP2   8'h08
`define UCC_OFS_COUNT  8'h0C
`define UCC_OFS_STATUS 8'h10
`define UCC_OFS_CLEAR  8'h14
`define UCC_OFS_RES1   8'h18
`define UCC_OFS_RES2   8'h1C
// Control register fields
`define UCC_CTRL_RELOAD 0
`define UCC_CTRL_DOWN   11
`define UCC_CTRL_FREE   12
`define UCC_CTRL_IRQ    13
`define UCC_CTRL_SYSCLK 14
`define UCC_CTRL_GATE   15
`define UCC_CTRL_ON     16
`define UCC_CTRL_W      17
`define UCC_CTRL_RST    17'h00000
// Channel configuration fields
`define UCC_CAP_FALL  0
`define UCC_CAP_CNT   1
`define UCC_CAP_IRQ   2
`define UCC_CAP_STAMP 3
`define UCC_CAP_PIN   4
`define UCC_CAP_PER   8
`define UCC_CAP_W     16
`define UCC_CAP_RST   16'h0000
// Clear register bits
`define UCC_CLR_TIMER 2
`endif

// ==== pkg/ucc_chan_if.sv ====
`timescale 1ns/1ns
interface ucc_chan_if;
  // Configuration from the register file
  logic                fall_sel;
  ucc_pkg::ucc_mode_e  mode;
  logic                stamp_rtc;
  logic [3:0]          pin_sel;
  ucc_pkg::ucc_period_t period_limit;
  logic                clear;
  // Shared timing and sources
  logic [11:0]         pins;
  logic                run;
  logic                tick;
  ucc_pkg::ucc_count_t timer_count;
  ucc_pkg::ucc_stamp_t rtc_count;
  // Channel state back to the register file
  logic                event_flag;
  logic                overrun;
  ucc_pkg::ucc_stamp_t result;
  modport top (output fall_sel, mode, stamp_rtc, pin_sel, period_limit,
               clear, pins, run, tick, timer_count, rtc_count,
               input event_flag, overrun, result);
  modport chan (input fall_sel, mode, stamp_rtc, pin_sel, period_limit,
                clear, pins, run, tick, timer_count, rtc_count,
                output event_flag, overrun, result);
endinterface : ucc_chan_if

// ==== pkg/ucc_pkg.sv ====
package ucc_pkg;
  typedef logic [10:0] ucc_count_t;   // Timer counter width
  typedef logic [21:0] ucc_stamp_t;   // Widest snapshot, RTC width
  typedef logic [7:0]  ucc_period_t;  // Period limit field
  typedef enum logic {
    UCC_CAPTURE,
    UCC_COUNTING
  } ucc_mode_e;
endpackage : ucc_pkg

// ==== rtl/ucc_channel.sv ====
`timescale 1ns/1ns
module ucc_channel (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Link to register file
  ucc_chan_if.chan ch
);
  logic                sel_lvl;
  logic                prev_lvl;
  logic                edge_hit;
  logic [7:0]          edge_cnt;
  ucc_pkg::ucc_stamp_t cyc_cnt;
  logic                done;
  ucc_pkg::ucc_stamp_t value;

  // Pin select; zero and codes above 12 select no pin
  always_comb begin
    sel_lvl = 1'b0;
    if (ch.pin_sel >= 4'h1 && ch.pin_sel <= 4'hC) begin
      sel_lvl = ch.pins[ch.pin_sel - 4'h1];
    end
  end

  // Edge polarity from the fall select bit
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) prev_lvl <= 1'b0;
    else prev_lvl <= sel_lvl;
  end
  assign edge_hit = ch.fall_sel ? (prev_lvl & ~sel_lvl)
                                : (~prev_lvl & sel_lvl);

  // Period counting; a group boundary edge also opens the next group.
  // The boundary cycle itself belongs to the new group, else one is lost.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      edge_cnt <= 8'h00;
      cyc_cnt  <= 22'h000000;
    end else if (!ch.run || ch.mode != ucc_pkg::UCC_COUNTING) begin
      edge_cnt <= 8'h00;
      cyc_cnt  <= 22'h000000;
    end else if (edge_hit && (edge_cnt == 8'h00 || done)) begin
      edge_cnt <= 8'h01;
      cyc_cnt  <= {21'h000000, ch.tick};
    end else begin
      if (edge_hit) edge_cnt <= edge_cnt + 8'h01;
      if (ch.tick) cyc_cnt <= cyc_cnt + 22'h000001;
    end
  end
  // Limit counts edges, so N periods need a limit of N plus one
  assign done = (edge_cnt != 8'h00) &&
                (edge_cnt == ch.period_limit - 8'h01);

  // Value stored on completion
  always_comb begin
    if (ch.mode == ucc_pkg::UCC_COUNTING) value = cyc_cnt;
    else if (ch.stamp_rtc) value = ch.rtc_count;
    else value = {11'h000, ch.timer_count};
  end

  // Event, overrun and result; a new event wins over a clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ch.event_flag <= 1'b0;
      ch.overrun    <= 1'b0;
      ch.result     <= 22'h000000;
    end else if (edge_hit && (ch.mode == ucc_pkg::UCC_CAPTURE || (ch.run
                 && done))) begin
      if (ch.event_flag && !ch.clear) begin
        ch.overrun <= 1'b1;
      end else begin
        ch.result     <= value;
        ch.event_flag <= 1'b1;
        ch.overrun    <= 1'b0;
      end
    end else if (ch.clear) begin
      ch.event_flag <= 1'b0;
      ch.overrun    <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_cap_edge;
    edge_hit && ch.mode == ucc_pkg::UCC_CAPTURE && !ch.event_flag;
  endsequence
  property p_capture;
    s_cap_edge |=> ch.event_flag && ch.result == $past(value);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not store value");
  property p_overrun;
    edge_hit && ch.mode == ucc_pkg::UCC_CAPTURE && ch.event_flag
      && !ch.clear |=> ch.overrun && $stable(ch.result);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");
  property p_clear;
    ch.clear && !edge_hit |=> !ch.event_flag && !ch.overrun;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear left flags set");
endmodule : ucc_channel

// ==== rtl/ucc_timer.sv ====
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "ucc_cfg.svh"
module ucc_timer (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output      logic [31:0] rdata,
  // Clock source and capture sources
  input  wire logic        low_power_clock,
  input  wire logic [11:0] gpio_in,
  input  wire logic [21:0] rtc_count,
  // Interrupt requests
  output      logic        timer_irq,
  output      logic [1:0]  chan_irq
);
  logic [`UCC_CTRL_W-1:0] ctrl;
  logic [`UCC_CAP_W-1:0]  cap_cfg [2];
  ucc_pkg::ucc_count_t    count;
  ucc_pkg::ucc_count_t    next_count;
  ucc_pkg::ucc_count_t    reload_value;
  logic                   count_direction_down;
  logic                   free_run_enable;
  logic                   timer_irq_enable;
  logic                   clock_source_select;
  logic                   timer_clock_gate;
  logic                   timer_on;
  logic                   run;
  logic                   tick;
  logic                   timer_flag;
  logic [1:0]             clr_chan;
  logic                   clr_timer;
  logic [2:0]             lp_sync;
  logic                   lp_lvl;
  logic                   lp_rise;
  logic [11:0]            pin_s1;
  logic [11:0]            pin_s2;
  logic [11:0]            pin_s3;
  logic [11:0]            pin_lvl;
  logic [31:0]            next_rdata;
  logic [1:0]             ev;
  logic [1:0]             ovr;
  ucc_pkg::ucc_stamp_t    res [2];

  // Control field views
  assign reload_value         = ctrl[`UCC_CTRL_RELOAD +: 11];
  assign count_direction_down = ctrl[`UCC_CTRL_DOWN];
  assign free_run_enable      = ctrl[`UCC_CTRL_FREE];
  assign timer_irq_enable     = ctrl[`UCC_CTRL_IRQ];
  assign clock_source_select  = ctrl[`UCC_CTRL_SYSCLK];
  assign timer_clock_gate     = ctrl[`UCC_CTRL_GATE];
  assign timer_on             = ctrl[`UCC_CTRL_ON];

  // Control register write
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `UCC_CTRL_RST;
    end else if (wr && addr == `UCC_OFS_CTRL) begin
      ctrl <= wdata[`UCC_CTRL_W-1:0];
    end
  end

  // Channel configuration writes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cap_cfg[0] <= `UCC_CAP_RST;
      cap_cfg[1] <= `UCC_CAP_RST;
    end else if (wr && addr == `UCC_OFS_CAP1) begin
      cap_cfg[0] <= wdata[`UCC_CAP_W-1:0];
    end else if (wr && addr == `UCC_OFS_CAP2) begin
      cap_cfg[1] <= wdata[`UCC_CAP_W-1:0];
    end
  end

  // Clear strobes are write-one pulses, they store nothing
  assign clr_chan  = (wr && addr == `UCC_OFS_CLEAR) ? wdata[1:0] : 2'h0;
  assign clr_timer = wr && addr == `UCC_OFS_CLEAR
                     && wdata[`UCC_CLR_TIMER];

  // Low-power clock synchroniser; only stages 2 and 3 are compared
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lp_sync <= 3'h0;
    end else begin
      lp_sync <= {lp_sync[1:0], low_power_clock};
    end
  end

  // Filtered low-power level and its rising edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lp_lvl  <= 1'b0;
      lp_rise <= 1'b0;
    end else begin
      lp_rise <= 1'b0;
      if (lp_sync[1] == lp_sync[2]) begin
        lp_lvl  <= lp_sync[2];
        lp_rise <= lp_sync[2] & ~lp_lvl;
      end
    end
  end

  // Pin synchronisers; a level is taken once stages 2 and 3 agree
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_s1 <= 12'h000;
      pin_s2 <= 12'h000;
      pin_s3 <= 12'h000;
    end else begin
      pin_s1 <= gpio_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Agreement filter per pin
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_lvl <= 12'h000;
    end else begin
      pin_lvl <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 ^ pin_s3));
    end
  end

  // Gate and enable both needed; low-power source ticks on its edge
  assign run  = timer_clock_gate && timer_on;
  assign tick = run && (clock_source_select || lp_rise);

  // Next counter value
  always_comb begin
    if (!run) begin
      next_count = 11'h000;
    end else if (!tick) begin
      next_count = count;
    end else if (count_direction_down) begin
      // Free run is ignored when counting down
      next_count = (count == 11'h000) ? reload_value
                                      : count - 11'h001;
    end else if (!free_run_enable && count == reload_value) begin
      next_count = 11'h000;
    end else begin
      next_count = count + 11'h001;
    end
  end

  // Counter register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) count <= 11'h000;
    else count <= next_count;
  end

  // Zero reached sets the timer flag; a new zero wins over a clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      timer_flag <= 1'b0;
    end else if (tick && next_count == 11'h000) begin
      timer_flag <= 1'b1;
    end else if (clr_timer) begin
      timer_flag <= 1'b0;
    end
  end

  // Interrupt outputs, registered so they stay glitch free
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      timer_irq <= 1'b0;
      chan_irq  <= 2'h0;
    end else begin
      timer_irq <= timer_flag && timer_irq_enable;
      chan_irq  <= ev & {cap_cfg[1][`UCC_CAP_IRQ],
                         cap_cfg[0][`UCC_CAP_IRQ]};
    end
  end

  // Two capture channels share the pins and timer state
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      ucc_chan_if cif ();
      assign cif.fall_sel     = cap_cfg[gi][`UCC_CAP_FALL];
      assign cif.mode         = ucc_pkg::ucc_mode_e'(
                                  cap_cfg[gi][`UCC_CAP_CNT]);
      assign cif.stamp_rtc    = cap_cfg[gi][`UCC_CAP_STAMP];
      assign cif.pin_sel      = cap_cfg[gi][`UCC_CAP_PIN +: 4];
      assign cif.period_limit = cap_cfg[gi][`UCC_CAP_PER +: 8];
      assign cif.clear        = clr_chan[gi];
      assign cif.pins         = pin_lvl;
      assign cif.run          = run;
      assign cif.tick         = tick;
      assign cif.timer_count  = count;
      assign cif.rtc_count    = rtc_count;
      assign ev[gi]           = cif.event_flag;
      assign ovr[gi]          = cif.overrun;
      assign res[gi]          = cif.result;
      ucc_channel u_chan (
        .mclk (mclk),
        .rstn (rstn),
        .ch   (cif.chan)
      );
    end
  endgenerate

  // Read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 32'h00000000;
    unique case (addr)
      `UCC_OFS_CTRL:   next_rdata = {15'h0000, ctrl};
      `UCC_OFS_CAP1:   next_rdata = {16'h0000, cap_cfg[0]};
      `UCC_OFS_CAP2:   next_rdata = {16'h0000, cap_cfg[1]};
      `UCC_OFS_COUNT:  next_rdata = {21'h000000, count};
      `UCC_OFS_STATUS: next_rdata = {27'h0000000, timer_flag, ovr, ev};
      `UCC_OFS_RES1:   next_rdata = {10'h000, res[0]};
      `UCC_OFS_RES2:   next_rdata = {10'h000, res[1]};
      default:         next_rdata = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) rdata <= 32'h00000000;
    else if (rd) rdata <= next_rdata;
    else rdata <= 32'h00000000;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_up_step;
    tick && !count_direction_down && !(free_run_enable == 1'b0
      && count == reload_value);
  endsequence
  sequence s_down_zero;
    tick && count_direction_down && count == 11'h000;
  endsequence
  sequence s_up_wrap;
    tick && !count_direction_down && free_run_enable
      && count == 11'h7FF;
  endsequence

  property p_up_step;
    s_up_step |=> count == $past(count) + 11'h001;
  endproperty
  a_up_step: assert property (p_up_step)
    else $error("up count step wrong");

  property p_down_reload;
    s_down_zero |=> count == $past(reload_value);
  endproperty
  a_down_reload: assert property (p_down_reload)
    else $error("down count did not reload");

  property p_threshold;
    tick && !count_direction_down && !free_run_enable
      && count == reload_value |=> count == 11'h000;
  endproperty
  a_threshold: assert property (p_threshold)
    else $error("threshold did not restart");

  property p_wrap_irq;
    s_up_wrap |=> count == 11'h000 && timer_flag
      ##1 timer_irq == timer_irq_enable;
  endproperty
  a_wrap_irq: assert property (p_wrap_irq)
    else $error("wrap did not flag zero");

  property p_stop;
    !run |=> count == 11'h000;
  endproperty
  a_stop: assert property (p_stop)
    else $error("counter moved while stopped");

  property p_lp_hold;
    run && !clock_source_select && !lp_rise |=> $stable(count);
  endproperty
  a_lp_hold: assert property (p_lp_hold)
    else $error("counter moved without lp edge");

  property p_irq_mask;
    !timer_irq_enable ##1 !timer_irq_enable |-> !timer_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("timer irq while disabled");

  property p_chan_irq;
    chan_irq[0] |-> $past(ev[0]) && $past(cap_cfg[0][`UCC_CAP_IRQ]);
  endproperty
  a_chan_irq: assert property (p_chan_irq)
    else $error("channel irq without enable");

  property p_result_first;
    $rose(chan_irq[0]) |-> $past(ev[0]) && $stable(res[0]);
  endproperty
  a_result_first: assert property (p_result_first)
    else $error("result not ready at irq");

  property p_read_once;
    !$past(rd) |-> rdata == 32'h00000000;
  endproperty
  a_read_once: assert property (p_read_once)
    else $error("read data outside read slot");
endmodule : ucc_timer

// ==== test/ucc_pin_model.sv ====
`timescale 1ns/1ns
// Far side of the timer: port pins, an RTC count and the slow clock
module ucc_pin_model (
  // Clock
  input  wire logic        mclk,
  // Pin levels and square wave request from the bench
  input  wire logic [11:0] pins,
  input  wire logic        wave_en,
  // Toward the timer
  output      logic [11:0] gpio_in,
  output      logic [21:0] rtc_count,
  output      logic        low_power_clock
);
  logic [3:0] wcnt;
  logic       wave;

  // RTC advances on mclk, so the unsynchronised sampling stays safe
  initial rtc_count = 22'h000000;
  always @(posedge mclk) rtc_count <= rtc_count + 22'h000001;

  // Slow clock runs free, phase unrelated to mclk
  initial begin
    low_power_clock = 1'b0;
    #7;
    forever #163 low_power_clock = ~low_power_clock;
  end

  // Pin 0 wave: 10 cycles high, 10 low, a period of 20 cycles
  initial begin
    wcnt = 4'h0;
    wave = 1'b0;
  end
  always @(posedge mclk) begin
    if (!wave_en) begin
      wcnt <= 4'h0;
      wave <= 1'b0;
    end else if (wcnt == 4'h9) begin
      wcnt <= 4'h0;
      wave <= ~wave;
    end else begin
      wcnt <= wcnt + 4'h1;
    end
  end

  // Bench levels with the wave laid over pin 0
  assign gpio_in = pins ^ {11'h000, wave};
endmodule : ucc_pin_model

// ==== test/updown_timer_capture_counter_tb.sv ====
`timescale 1ns/1ns
`include "ucc_cfg.svh"
module updown_timer_capture_counter_tb;
  logic        mclk, rstn, wr, rd, wave_en, low_power_clock, timer_irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v, w;
  logic [11:0] pins, gpio_in;
  logic [21:0] rtc_count, r0;
  logic [1:0]  chan_irq;
  logic [2:0]  irqs;
  int          errors, n_checks;
  localparam logic [31:0] RUN = (32'h1 << `UCC_CTRL_GATE) |
    (32'h1 << `UCC_CTRL_ON) | (32'h1 << `UCC_CTRL_SYSCLK);
  localparam logic [31:0] FREE = 32'h1 << `UCC_CTRL_FREE;
  localparam logic [31:0] TIRQ = 32'h1 << `UCC_CTRL_IRQ;

  assign irqs = {chan_irq, timer_irq};

  ucc_timer uut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .low_power_clock(low_power_clock),
    .gpio_in(gpio_in), .rtc_count(rtc_count), .timer_irq(timer_irq),
    .chan_irq(chan_irq));
  ucc_pin_model far (.mclk(mclk), .pins(pins), .wave_en(wave_en),
    .gpio_in(gpio_in), .rtc_count(rtc_count),
    .low_power_clock(low_power_clock));

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic in_range(input string name, input logic [31:0] x,
                          input logic [31:0] lo, input logic [31:0] hi);
    check(name, {31'h0, (x >= lo) && (x <= hi)}, 32'h1);
  endtask : in_range

  task automatic end_of_test();
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // Bus cycles: one strobe cycle, then a free cycle before the next
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  // Pin change, with time for the 4 to 5 cycle input path
  task automatic pin(input int i, input logic val);
    @(posedge mclk);
    r0 = rtc_count;
    pins[i] <= val;
    idle(8);
  endtask : pin

  task automatic wait_irq(input int b);
    int i;
    i = 0;
    while (i < 2200 && irqs[b] !== 1'b1) begin
      @(posedge mclk);
      i++;
    end
    if (i == 2200) begin
      errors++;
      $display("ERROR irq %0d never rose", b);
      end_of_test();
    end
  endtask : wait_irq

  task automatic t_reset();
    logic [7:0] a[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18,
                         8'h1C, 8'h20};
    wr_reg(8'h20, 32'hFFFFFFFF);
    foreach (a[i]) begin
      rd_reg(a[i], v);
      check("reset reg", v, 32'h0);
    end
    check("irqs at reset", {29'h0, irqs}, 32'h0);
  endtask : t_reset

  task automatic t_gate();
    wr_reg(`UCC_OFS_CTRL, RUN & ~(32'h1 << `UCC_CTRL_ON));
    idle(4);
    rd_reg(`UCC_OFS_COUNT, v);
    check("count gate only", v, 32'h0);
    wr_reg(`UCC_OFS_CTRL, RUN & ~(32'h1 << `UCC_CTRL_GATE));
    idle(4);
    rd_reg(`UCC_OFS_COUNT, v);
    check("count on only", v, 32'h0);
  endtask : t_gate

  // Reads are two cycles apart; reload 5 gives a cycle of six
  task automatic t_updown();
    wr_reg(`UCC_OFS_CTRL, RUN | 32'h5);
    idle(3);
    rd_reg(`UCC_OFS_COUNT, v);
    rd_reg(`UCC_OFS_COUNT, w);
    check("count up", w, (v + 32'h2) % 32'h6);
    wr_reg(`UCC_OFS_CTRL, RUN | (32'h1 << `UCC_CTRL_DOWN) | 32'h5);
    idle(3);
    rd_reg(`UCC_OFS_COUNT, v);
    rd_reg(`UCC_OFS_COUNT, w);
    check("count down", w, (v + 32'h4) % 32'h6);
  endtask : t_updown

  // Zero flag left by the threshold runs must go before the irq is enabled
  task automatic t_free();
    wr_reg(`UCC_OFS_CTRL, 32'h0);
    wr_reg(`UCC_OFS_CLEAR, 32'h1 << `UCC_CLR_TIMER);
    wr_reg(`UCC_OFS_CTRL, RUN | FREE | TIRQ | 32'h5);
    idle(12);
    rd_reg(`UCC_OFS_COUNT, v);
    in_range("free past reload", v, 32'h6, 32'h7FF);
    check("no irq before wrap", {31'h0, timer_irq}, 32'h0);
    wait_irq(0);
    rd_reg(`UCC_OFS_COUNT, v);
    in_range("count after wrap", v, 32'h0, 32'h8);
    wr_reg(`UCC_OFS_CTRL, RUN | FREE | 32'h5);
    idle(3);
    check("timer irq masked", {31'h0, timer_irq}, 32'h0);
    rd_reg(`UCC_OFS_STATUS, v);
    check("timer flag", v & 32'h10, 32'h10);
    wr_reg(`UCC_OFS_CTRL, 32'h0);
    wr_reg(`UCC_OFS_CLEAR, 32'h1 << `UCC_CLR_TIMER);
    rd_reg(`UCC_OFS_STATUS, v);
    check("timer flag cleared", v & 32'h10, 32'h0);
  endtask : t_free

  // Slow clock of about 16 cycles: 64 cycles give a handful of ticks
  task automatic t_lp();
    wr_reg(`UCC_OFS_CTRL, RUN & ~(32'h1 << `UCC_CTRL_SYSCLK) | 32'h7FF);
    // Bus clock stays undivided while the slow clock drives the timer
    idle(64);
    rd_reg(`UCC_OFS_COUNT, v);
    in_range("slow clock count", v, 32'h2, 32'h5);
  endtask : t_lp

  task automatic t_capture();
    wr_reg(`UCC_OFS_CTRL, 32'h0);
    wr_reg(`UCC_OFS_CTRL, RUN | FREE | 32'h7FF);
    wr_reg(`UCC_OFS_CAP1, 32'h1C); // RTC source, irq on, pin 0
    pin(0, 1'b1);
    check("ch1 irq", {30'h0, chan_irq}, 32'h1);
    rd_reg(`UCC_OFS_RES1, w);
    in_range("rtc stamp", w, r0 + 32'h3, r0 + 32'h8);
    pin(0, 1'b0);
    pin(0, 1'b1);
    rd_reg(`UCC_OFS_STATUS, v);
    check("overrun", v, 32'h5);
    rd_reg(`UCC_OFS_RES1, v);
    check("stamp kept", v, w);
    wr_reg(`UCC_OFS_CLEAR, 32'h1);
    rd_reg(`UCC_OFS_STATUS, v);
    check("event cleared", v, 32'h0);
    check("ch1 irq cleared", {30'h0, chan_irq}, 32'h0);
    wr_reg(`UCC_OFS_CAP1, 32'h14); // Timer source
    pin(0, 1'b0);
    rd_reg(`UCC_OFS_COUNT, v);
    pin(0, 1'b1);
    rd_reg(`UCC_OFS_RES1, w);
    in_range("timer stamp", w, v + 32'h3, v + 32'hA);
    wr_reg(`UCC_OFS_CLEAR, 32'h1);
  endtask : t_capture

  task automatic t_ch2();
    wr_reg(`UCC_OFS_CAP2, 32'hC9); // Falling, RTC, irq off, pin 11
    pin(0, 1'b0);
    pin(11, 1'b1);
    rd_reg(`UCC_OFS_STATUS, v);
    check("ch2 ignores", v, 32'h0);
    pin(11, 1'b0);
    rd_reg(`UCC_OFS_STATUS, v);
    check("ch2 event", v, 32'h2);
    check("ch2 irq off", {30'h0, chan_irq}, 32'h0);
    wr_reg(`UCC_OFS_CAP2, 32'hCD);
    idle(3);
    check("ch2 irq on", {30'h0, chan_irq}, 32'h2);
    wr_reg(`UCC_OFS_CLEAR, 32'h2);
    wr_reg(`UCC_OFS_CAP2, 32'h0);
  endtask : t_ch2

  // Limit 3 means two periods of 20 cycles: 40 cycles each group
  task automatic t_count();
    wr_reg(`UCC_OFS_CAP1, 32'h316);
    wave_en <= 1'b1;
    wait_irq(1);
    rd_reg(`UCC_OFS_RES1, v);
    check("group count", v, 32'h28);
    wr_reg(`UCC_OFS_CLEAR, 32'h1);
    idle(2);
    wait_irq(1);
    rd_reg(`UCC_OFS_RES1, v);
    check("next group", v, 32'h28);
    wave_en <= 1'b0;
  endtask : t_count

  // Main sequence
  initial begin
    rstn    = 1'b0;
    wr      = 1'b0;
    rd      = 1'b0;
    addr    = 8'h00;
    wdata   = 32'h0;
    pins    = 12'h000;
    wave_en = 1'b0;
    errors   = 0;
    n_checks = 0;
    idle(12);
    rstn <= 1'b1;
    t_reset();
    t_gate();
    t_updown();
    t_free();
    t_lp();
    t_capture();
    t_ch2();
    t_count();
    end_of_test();
  end
endmodule : updown_timer_capture_counter_tb
